/* File: verilog/nalu_map.svh */
// Constant map of the nibble accumulator logic unit.
// Assumes 10-bit instruction words delivered in 16-bit padded form.
`ifndef NALU_MAP_SVH
`define NALU_MAP_SVH

// Padded 16-bit word: bits 15:13 and 7:5 hold the 111 pad
`define NALU_W16_HI_MSB   12
`define NALU_W16_HI_LSB   8
`define NALU_W16_LO_MSB   4
`define NALU_W16_LO_LSB   0
`define NALU_PAD_VALUE    3'h7

// Upper five bits of the 10-bit word
`define NALU_HI_AND_LOW   5'h1b
`define NALU_HI_AND_HIGH  5'h1a
`define NALU_HI_OR_LOW    5'h1d
`define NALU_HI_OR_HIGH   5'h1c
`define NALU_HI_XOR_LOW   5'h15
`define NALU_HI_XOR_HIGH  5'h14
`define NALU_HI_INC       5'h14
`define NALU_HI_ROT       5'h1c
`define NALU_HI_ROTZ      5'h1e

// Lower five bits of the 10-bit word
`define NALU_LO_REG_BIT   4
`define NALU_LO_TABLE     5'h10
`define NALU_LO_IMM       5'h11
`define NALU_LO_ACC       5'h13

// Table word nibbles, carry term bit
`define NALU_TBL_HI_MSB   7
`define NALU_TBL_HI_LSB   4
`define NALU_TBL_LO_MSB   3
`define NALU_TBL_LO_LSB   0
`define NALU_SIGN_BIT     3

// Reset values
`define NALU_ACC_RST      4'h0
`define NALU_CARRY_RST    1'b0

`endif

/* File: verilog/nalu_pkg.sv */
// Types of the nibble accumulator logic unit.
// Assumes nalu_map.svh supplies the numeric constants.
package nalu_pkg;

    // Operands that the core presents with each instruction cycle
    typedef struct packed {
        logic [3:0]  reg_data;     // Addressed low_bank_reg or high_bank_reg
        logic [9:0]  table_word;   // Word at table_page_register, pointer_register_zero
        logic [15:0] second_word;  // Padded second word carrying immediate_nibble
    } nalu_operand_s;

    typedef enum logic [2:0] {
        NALU_OP_NONE = 3'h0,
        NALU_OP_AND  = 3'h1,
        NALU_OP_OR   = 3'h3,
        NALU_OP_XOR  = 3'h2,
        NALU_OP_INC  = 3'h6,
        NALU_OP_ROT  = 3'h7,
        NALU_OP_ROTZ = 3'h5
    } nalu_op_e;

endpackage : nalu_pkg

/* File: verilog/nalu_accum.sv */
// Accumulator and carry datapath with its instruction decoder.
// Assumes the core presents each instruction word and its operands for
// one clock with instr_valid; every instruction completes in that cycle.
//
// Functional notes
// - Ten-bit words; ignore both 111 pad groups
// - Register AND; carry is A3 and R3
// - Table AND high/low nibble; carry from nibble top
// - Immediate AND; carry is A3 and imm3
// - Register OR; carry always cleared
// - Table OR high/low nibble; carry cleared
// - Immediate OR; carry cleared
// - XOR register or immediate; carry A3 and operand3
// - Table XOR; carry A3 and word bit
// - Increment modulo sixteen; carry on wrap
// - Rotate left through bit 0; carry old A3
// - Rotate-or-reset resets when accumulator zero
// - That reset clears carry like any reset
`timescale 1ns/1ps
`include "nalu_map.svh"

module nalu_accum (
    input  wire logic                  clk,            // 200 MHz system clock
    input  wire logic                  rst_b,          // Chip reset, active low
    input  wire logic                  instr_valid,    // Instruction cycle strobe
    input  wire logic [15:0]           instr_word,     // First word, padded form
    input  wire nalu_pkg::nalu_operand_s operands,     // Operands for this cycle
    input  wire logic                  acc_load,       // Load from other instructions
    input  wire logic [3:0]            acc_load_data,  // Value for acc_load
    output logic [3:0]                 acc,            // Accumulator
    output logic                       carry_flag,     // Carry flag
    output logic                       reset_request,  // Zero-rotate reset pulse
    output logic                       instr_done      // Group instruction executed
);

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic [3:0]  acc_reg;
    logic [3:0]  acc_next;
    logic        carry_reg;
    logic        carry_next;
    logic        reset_req_reg;
    logic        reset_req_next;
    logic        done_reg;
    logic        done_next;
    logic [9:0]  word10;
    logic [4:0]  op_hi;
    logic [4:0]  op_lo;
    logic [9:0]  second10;
    logic [3:0]  imm_nibble;
    logic [3:0]  tbl_nibble;
    logic [3:0]  operand;
    nalu_pkg::nalu_op_e op;

    // Drops the two pad groups of a padded word
    function automatic logic [9:0] strip_pad(input logic [15:0] w);
        strip_pad = {w[`NALU_W16_HI_MSB:`NALU_W16_HI_LSB],
                     w[`NALU_W16_LO_MSB:`NALU_W16_LO_LSB]};
    endfunction : strip_pad

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign word10     = strip_pad(instr_word);
    assign op_hi      = word10[9:5];
    assign op_lo      = word10[4:0];
    assign second10   = strip_pad(operands.second_word);
    assign imm_nibble = second10[3:0];

    // Decode
    always_comb begin
        op = nalu_pkg::NALU_OP_NONE;
        if (!op_lo[`NALU_LO_REG_BIT] || op_lo == `NALU_LO_TABLE) begin
            case (op_hi)
                `NALU_HI_AND_LOW, `NALU_HI_AND_HIGH: op = nalu_pkg::NALU_OP_AND;
                `NALU_HI_OR_LOW,  `NALU_HI_OR_HIGH:  op = nalu_pkg::NALU_OP_OR;
                `NALU_HI_XOR_LOW, `NALU_HI_XOR_HIGH: op = nalu_pkg::NALU_OP_XOR;
                default: op = nalu_pkg::NALU_OP_NONE;
            endcase
        end else if (op_lo == `NALU_LO_IMM) begin
            case (op_hi)
                `NALU_HI_AND_LOW: op = nalu_pkg::NALU_OP_AND;
                `NALU_HI_OR_LOW:  op = nalu_pkg::NALU_OP_OR;
                `NALU_HI_XOR_LOW: op = nalu_pkg::NALU_OP_XOR;
                default: op = nalu_pkg::NALU_OP_NONE;
            endcase
        end else if (op_lo == `NALU_LO_ACC) begin
            case (op_hi)
                `NALU_HI_INC:  op = nalu_pkg::NALU_OP_INC;
                `NALU_HI_ROT:  op = nalu_pkg::NALU_OP_ROT;
                `NALU_HI_ROTZ: op = nalu_pkg::NALU_OP_ROTZ;
                default: op = nalu_pkg::NALU_OP_NONE;
            endcase
        end
    end

    // Operand select: even upper code takes the high table nibble
    always_comb begin
        if (op_hi[0]) begin
            tbl_nibble = operands.table_word[`NALU_TBL_LO_MSB:`NALU_TBL_LO_LSB];
        end else begin
            tbl_nibble = operands.table_word[`NALU_TBL_HI_MSB:`NALU_TBL_HI_LSB];
        end
        if (!op_lo[`NALU_LO_REG_BIT]) begin
            operand = operands.reg_data;
        end else if (op_lo == `NALU_LO_TABLE) begin
            operand = tbl_nibble;
        end else begin
            operand = imm_nibble;
        end
    end

    // Execute
    always_comb begin
        acc_next       = acc_reg;
        carry_next     = carry_reg;
        reset_req_next = 1'b0;
        done_next      = 1'b0;
        if (instr_valid) begin
            done_next = (op != nalu_pkg::NALU_OP_NONE);
            case (op)
                nalu_pkg::NALU_OP_AND: begin
                    acc_next   = acc_reg & operand;
                    carry_next = acc_reg[`NALU_SIGN_BIT] & operand[`NALU_SIGN_BIT];
                end
                nalu_pkg::NALU_OP_OR: begin
                    acc_next   = acc_reg | operand;
                    carry_next = 1'b0;
                end
                nalu_pkg::NALU_OP_XOR: begin
                    acc_next   = acc_reg ^ operand;
                    carry_next = acc_reg[`NALU_SIGN_BIT] & operand[`NALU_SIGN_BIT];
                end
                nalu_pkg::NALU_OP_INC: begin
                    acc_next   = acc_reg + 4'h1;
                    carry_next = (acc_reg == 4'hf);
                end
                nalu_pkg::NALU_OP_ROT: begin
                    acc_next   = {acc_reg[2:0], acc_reg[3]};
                    carry_next = acc_reg[3];
                end
                nalu_pkg::NALU_OP_ROTZ: begin
                    if (acc_reg == 4'h0) begin
                        reset_req_next = 1'b1;
                        carry_next     = `NALU_CARRY_RST;
                    end else begin
                        acc_next   = {acc_reg[2:0], acc_reg[3]};
                        carry_next = acc_reg[3];
                    end
                end
                default: begin
                    if (acc_load) begin
                        acc_next   = acc_load_data;
                        carry_next = 1'b0;
                    end
                end
            endcase
        end else if (acc_load) begin
            acc_next   = acc_load_data;
            carry_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            acc_reg       <= `NALU_ACC_RST;
            carry_reg     <= `NALU_CARRY_RST;
            reset_req_reg <= 1'b0;
            done_reg      <= 1'b0;
        end else begin
            acc_reg       <= acc_next;
            carry_reg     <= carry_next;
            reset_req_reg <= reset_req_next;
            done_reg      <= done_next;
        end
    end

    assign acc           = acc_reg;
    assign carry_flag    = carry_reg;
    assign reset_request = reset_req_reg;
    assign instr_done    = done_reg;

    // Checks
    logic [3:0] reg_opnd;
    logic [3:0] imm_opnd;
    logic [9:0] tbl_opnd;
    logic       go;
    assign reg_opnd = operands.reg_data;
    assign imm_opnd = imm_nibble;
    assign tbl_opnd = operands.table_word;
    assign go       = instr_valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_reg);

    property p_pad_ignored;
        go && instr_word[7:5] != `NALU_PAD_VALUE && word10 == {5'h1b, 5'h11}
            |=> acc == ($past(acc_reg) & $past(imm_opnd));
    endproperty
    a_pad_ignored: assert property (p_pad_ignored) else $error("Pad bits changed decode");

    property p_and_reg;
        go && op_hi == `NALU_HI_AND_HIGH && !op_lo[4]
            |=> acc == ($past(acc_reg) & $past(reg_opnd))
                && carry_flag == ($past(acc_reg[3]) & $past(reg_opnd[3]));
    endproperty
    a_and_reg: assert property (p_and_reg) else $error("Register AND wrong");

    property p_and_tbl_hi;
        go && word10 == {5'h1a, 5'h10}
            |=> acc == ($past(acc_reg) & $past(tbl_opnd[7:4]))
                && carry_flag == ($past(acc_reg[3]) & $past(tbl_opnd[7]));
    endproperty
    a_and_tbl_hi: assert property (p_and_tbl_hi) else $error("Table AND high wrong");

    property p_and_imm;
        go && word10 == {5'h1b, 5'h11}
            |=> carry_flag == ($past(acc_reg[3]) & $past(imm_opnd[3]));
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("Immediate AND carry wrong");

    property p_or_clears;
        go && (op_hi == 5'h1d || op_hi == 5'h1c) && !op_lo[4] ##1 1'b1
            |-> !carry_flag && acc == ($past(acc_reg) | $past(reg_opnd));
    endproperty
    a_or_clears: assert property (p_or_clears) else $error("Register OR wrong");

    property p_or_tbl_lo;
        go && word10 == {5'h1d, 5'h10}
            |=> !carry_flag && acc == ($past(acc_reg) | $past(tbl_opnd[3:0]));
    endproperty
    a_or_tbl_lo: assert property (p_or_tbl_lo) else $error("Table OR low wrong");

    property p_or_imm;
        go && word10 == {5'h1d, 5'h11} |=> !carry_flag && instr_done;
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("Immediate OR wrong");

    property p_xor_reg;
        go && op_hi == 5'h15 && !op_lo[4]
            |=> acc == ($past(acc_reg) ^ $past(reg_opnd));
    endproperty
    a_xor_reg: assert property (p_xor_reg) else $error("Register XOR wrong");

    property p_xor_tbl_lo;
        go && word10 == {5'h15, 5'h10}
            |=> carry_flag == ($past(acc_reg[3]) & $past(tbl_opnd[3]));
    endproperty
    a_xor_tbl_lo: assert property (p_xor_tbl_lo) else $error("Table XOR carry wrong");

    property p_inc;
        go && word10 == {5'h14, 5'h13}
            |=> acc == $past(acc_reg) + 4'h1 && carry_flag == (acc == 4'h0);
    endproperty
    a_inc: assert property (p_inc) else $error("Increment wrong");

    property p_rot;
        go && word10 == {5'h1c, 5'h13}
            |=> acc == {$past(acc_reg[2:0]), $past(acc_reg[3])}
                && carry_flag == $past(acc_reg[3]);
    endproperty
    a_rot: assert property (p_rot) else $error("Rotate left wrong");

    property p_rotz;
        go && word10 == {5'h1e, 5'h13} && acc_reg == 4'h0
            |=> reset_request && !carry_flag ##1 !reset_request;
    endproperty
    a_rotz: assert property (p_rotz) else $error("Zero rotate reset missing");

    property p_rotz_nz;
        go && word10 == {5'h1e, 5'h13} && acc_reg != 4'h0 |=> !reset_request;
    endproperty
    a_rotz_nz: assert property (p_rotz_nz) else $error("Spurious reset request");

    c_rotz_reset: cover property (go && word10 == {5'h1e, 5'h13} && acc_reg == 4'h0);
    c_inc_wrap:   cover property (go && word10 == {5'h14, 5'h13} && acc_reg == 4'hf);
    c_and_imm:    cover property (go && word10 == {5'h1b, 5'h11} ##1 carry_flag);
    c_xor_tbl:    cover property (go && word10 == {5'h14, 5'h10});

endmodule : nalu_accum

/* File: bench/nalu_accum_tb_top.sv */
// Self-checking bench for the nibble accumulator logic unit.
// Assumes nalu_accum checks itself with in-file assertions; bench drives every input.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module nalu_accum_tb_top;
    logic                    clk           = 1'b0;
    logic                    rst_b         = 1'b0;
    logic                    instr_valid   = 1'b0;
    logic [15:0]             instr_word    = 16'h0000;
    nalu_pkg::nalu_operand_s operands      = '0;
    logic                    acc_load      = 1'b0;
    logic [3:0]              acc_load_data = 4'h0;
    logic [3:0]              acc;
    logic                    carry_flag;
    logic                    reset_request;
    logic                    instr_done;
    int                      errors        = 0;
    int                      check_count   = 0;

    always #2.5 clk = ~clk;

    nalu_accum dut (
        .clk           (clk),
        .rst_b         (rst_b),
        .instr_valid   (instr_valid),
        .instr_word    (instr_word),
        .operands      (operands),
        .acc_load      (acc_load),
        .acc_load_data (acc_load_data),
        .acc           (acc),
        .carry_flag    (carry_flag),
        .reset_request (reset_request),
        .instr_done    (instr_done)
    );

    task automatic give_verdict;
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // One group instruction; valid stays up so calls run back to back
    task automatic run(input logic [15:0] w, input logic [3:0] r, input logic [9:0] t,
                       input logic [15:0] s, input logic [3:0] ea, input logic ec,
                       input logic er = 1'b0);
        acc_load    = 1'b0;
        instr_valid = 1'b1;
        instr_word  = w;
        operands    = {r, t, s};
        @(posedge clk);
        @(negedge clk);
        `CHK("acc", ea, acc)
        `CHK("carry_flag", ec, carry_flag)
        `CHK("reset_request", er, reset_request)
        if (!er) begin
            `CHK("instr_done", 1'b1, instr_done)
        end
    endtask : run

    task automatic load(input logic [3:0] v);
        instr_valid   = 1'b0;
        acc_load      = 1'b1;
        acc_load_data = v;
        @(posedge clk);
        @(negedge clk);
        `CHK("acc_load", v, acc)
    endtask : load

    task automatic t_and;
        load(4'hc);
        run(16'hfbe3, 4'ha, 10'h000, 16'hfff0, 4'h8, 1'b1);
        run(16'hfae5, 4'h7, 10'h000, 16'hfff0, 4'h0, 1'b0);
        load(4'hf);
        run(16'hfbf0, 4'h0, 10'h06c, 16'hfff0, 4'hc, 1'b1);
        run(16'hfaf0, 4'h0, 10'h3e0, 16'hfff0, 4'hc, 1'b1);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfffa, 4'h8, 1'b1);
        load(4'hc);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff5, 4'h4, 1'b0);
    endtask : t_and

    // Each OR follows an AND that leaves carry set
    task automatic t_or;
        load(4'h8);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff8, 4'h8, 1'b1);
        run(16'hfde1, 4'h1, 10'h000, 16'hfff0, 4'h9, 1'b0);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff9, 4'h9, 1'b1);
        run(16'hfce2, 4'h4, 10'h000, 16'hfff0, 4'hd, 1'b0);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfffd, 4'hd, 1'b1);
        run(16'hfcf0, 4'h0, 10'h0e3, 16'hfff0, 4'hf, 1'b0);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff8, 4'h8, 1'b1);
        run(16'hfdf0, 4'h0, 10'h0e3, 16'hfff0, 4'hb, 1'b0);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff8, 4'h8, 1'b1);
        run(16'hfdf1, 4'h0, 10'h000, 16'hfff6, 4'he, 1'b0);
    endtask : t_or

    task automatic t_xor;
        load(4'hf);
        run(16'hf5e0, 4'h9, 10'h000, 16'hfff0, 4'h6, 1'b1);
        run(16'hf4e7, 4'ha, 10'h000, 16'hfff0, 4'hc, 1'b0);
        run(16'hf5f1, 4'h0, 10'h000, 16'hfffb, 4'h7, 1'b1);
        run(16'hf4f0, 4'h0, 10'h3e0, 16'hfff0, 4'h9, 1'b0);
        run(16'hf5f0, 4'h0, 10'h0ec, 16'hfff0, 4'h5, 1'b1);
    endtask : t_xor

    task automatic t_inc;
        load(4'he);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'hf, 1'b0);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'h0, 1'b1);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'h1, 1'b0);
        // Pad groups cleared to zero must not change decoding
        run(16'h1413, 4'h0, 10'h000, 16'h0000, 4'h2, 1'b0);
        run(16'h1b11, 4'h0, 10'h000, 16'h0003, 4'h2, 1'b0);
    endtask : t_inc

    task automatic t_rot;
        load(4'h9);
        run(16'hfcf3, 4'h0, 10'h000, 16'hfff0, 4'h3, 1'b1);
        run(16'hfcf3, 4'h0, 10'h000, 16'hfff0, 4'h6, 1'b0);
        run(16'hfef3, 4'h0, 10'h000, 16'hfff0, 4'hc, 1'b0);
        run(16'hfef3, 4'h0, 10'h000, 16'hfff0, 4'h9, 1'b1);
        load(4'hf);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'h0, 1'b1);
        run(16'hfef3, 4'h0, 10'h000, 16'hfff0, 4'h0, 1'b0, 1'b1);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'h1, 1'b0);
    endtask : t_rot

    // Refused opcode, then a group op racing a load in one cycle
    task automatic t_misc;
        load(4'h5);
        instr_valid = 1'b1;
        instr_word  = 16'hffe0;
        acc_load    = 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("refused acc", 4'h5, acc)
        `CHK("refused done", 1'b0, instr_done)
        instr_word    = 16'hf4f3;
        acc_load      = 1'b1;
        acc_load_data = 4'h3;
        @(posedge clk);
        @(negedge clk);
        `CHK("priority acc", 4'h6, acc)
    endtask : t_misc

    // Mid-run chip reset clears carry at once
    task automatic t_reset;
        load(4'hf);
        run(16'hfbf1, 4'h0, 10'h000, 16'hfff8, 4'h8, 1'b1);
        instr_valid = 1'b0;
        #1;
        rst_b = 1'b0;
        #1;
        `CHK("reset carry", 1'b0, carry_flag)
        `CHK("reset pulse", 1'b0, reset_request)
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        load(4'h2);
        run(16'hf4f3, 4'h0, 10'h000, 16'hfff0, 4'h3, 1'b0);
    endtask : t_reset

    initial begin
        #20000;
        errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        t_and();
        t_or();
        t_xor();
        t_inc();
        t_rot();
        t_misc();
        t_reset();
        give_verdict();
    end
endmodule : nalu_accum_tb_top
